//--- design/status_one_pkg.sv
// Constants shared by the status register one protection block
package status_one_pkg;

  // Command codes seen on the serial link
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_VOL_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_REGISTER_WRITE = 8'h01;
  localparam logic [7:0] CMD_ANY_REGISTER_WRITE = 8'h71;
  localparam logic [7:0] CMD_ANY_REGISTER_READ = 8'h65;
  localparam logic [7:0] CMD_STATUS_ONE_READ = 8'h05;
  localparam logic [7:0] CMD_STATUS_TWO_READ = 8'h07;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_SOFT_RESET_ARM = 8'h66;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h99;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'hD8;
  localparam logic [7:0] CMD_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] CMD_CHIP_ERASE_B = 8'hC7;

  // Register addresses used by the any-register write
  localparam logic [23:0] ADDR_STATUS_ONE_NV = 24'h000000;
  localparam logic [23:0] ADDR_STATUS_ONE_V = 24'h800000;

  // Field positions of status register one (both copies)
  localparam int BIT_PROTECT_LOCK = 7;
  localparam int BIT_GRANULE = 6;
  localparam int BIT_TOP_BOTTOM = 5;
  localparam int BP_MSB = 4;
  localparam int BP_LSB = 2;
  localparam int BIT_WRITE_LATCH = 1;
  localparam int BIT_BUSY = 0;

  // Field positions of status register two
  localparam int BIT_ERASE_ERR = 6;
  localparam int BIT_PROG_ERR = 5;

  // Reset and factory default values
  localparam logic PROTECT_LOCK_RST = 1'b0;
  localparam logic GRANULE_RST = 1'b0;
  localparam logic TOP_BOTTOM_RST = 1'b0;
  localparam logic [2:0] BLOCK_PROTECT_RST = 3'h0;
  localparam logic WRITE_LATCH_DEFAULT = 1'b0;
  localparam logic BUSY_FLAG_DEFAULT = 1'b0;

  // Frame byte counts for register writes
  localparam logic [2:0] BYTES_REG_WRITE = 3'h2;
  localparam logic [2:0] BYTES_ANY_WRITE = 3'h5;

endpackage

//--- design/status_one_protection.sv
// Status register one with write latch, busy flag and register protection
//
// Overview of operation
// - Non-volatile lock default bit 7 seeds the lock bit, resets to zero.
// - Non-volatile block-protect defaults seed the volatile field, reset zero.
// - Write-latch default is fixed, read only, loaded into bit 1 on reset.
// - Busy default is fixed, read only, loaded into bit 0 on reset.
// - Lock set with write-protect low ignores all register writes.
// - Lock clear allows register writes whatever the write-protect level.
// - Write-protect gates only status, configuration and learning registers.
// - Lock bit follows every change of its non-volatile default.
// - Quad or four-wire mode forces internal write-protect high.
// - Granule select picks 4 KB sectors when 1, 64 KB blocks when 0.
// - Top-bottom select anchors range at top when 0, bottom when 1.
// - Top-bottom bit follows every change of its non-volatile default.
// - Block-protect field selects region from 1/64 to whole array.
// - Write latch must be set first; 06h and 50h set, 04h clears.
// - Successful operation clears write latch; clear-status clears it too.
// - Power-up, hardware and software reset load write latch default.
// - Register writes leave write latch and busy flag bits untouched.
// - While busy only reads, suspend, clear-status and reset pair pass.
// - Suspend accepted only while an array operation runs.
// - Error flag keeps busy set until clear-status arrives.
// - Status one read returns the volatile status register.
// - Clear-status resets erase and program error flags.
`timescale 1ns/1ns
module status_one_protection
  import status_one_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = 16
) (
  // Core clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Serial link
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  // Write-protect pin and interface modes
  input wire logic i_wp_n,
  input wire logic i_four_wire_mode,
  input wire logic i_quad_mode,
  // Array engine handshake
  input wire logic i_op_done,
  input wire logic i_op_fail,
  output logic o_op_start,
  output logic o_op_erase,
  output logic o_suspend,
  // Protection state toward the rest of the device
  output logic o_register_lock,
  output logic o_granule_select,
  output logic o_top_bottom,
  output logic [2:0] o_block_protect,
  output logic o_write_enable,
  output logic o_busy
);

  // Refuse timer lengths the 16-bit counter cannot hold; below 8 the
  // busy-length check would trip on a legal setting
  if (NV_WRITE_CYCLES < 8 || NV_WRITE_CYCLES > 65535) begin : g_chk
    $error("NV_WRITE_CYCLES out of range");
  end

  // Link domain state
  logic [2:0] bit_cnt;
  logic cmd_done;
  logic [7:0] link_cmd;
  logic [7:0] shifter;
  logic [7:0] byte_hold;
  logic byte_tgl;
  logic [7:0] out_sh;
  // Core domain state
  logic [1:0] wp_s;
  logic [3:0] cs_s;
  logic [2:0] tgl_s;
  logic [2:0] byte_idx;
  logic [7:0] fcmd;
  logic [23:0] faddr;
  logic [7:0] fdata;
  logic nv_lock, nv_gran, nv_tb;
  logic [2:0] nv_bp;
  logic protect_lock, granule_select, top_bottom_select;
  logic [2:0] block_protect_field;
  logic write_enable_latch, busy_flag, vol_only;
  logic arr_run, arr_erase, nv_busy, rst_armed;
  logic [15:0] nv_timer;
  logic prog_err, erase_err;
  logic [7:0] snap_one, snap_two;

  // Link logic idles whenever the frame is closed or the core is reset
  wire link_idle = i_cs_n | ~i_reset_n;
  wire byte_end = bit_cnt == 3'h7;
  wire [7:0] next_shift = {shifter[6:0], i_si};
  wire link_is_read = link_cmd == CMD_STATUS_ONE_READ ||
                      link_cmd == CMD_STATUS_TWO_READ;
  wire [7:0] snap_sel = (link_cmd == CMD_STATUS_TWO_READ) ? snap_two
                                                          : snap_one;
  wire load_out = cmd_done && bit_cnt == 3'h0 && link_is_read;

  // Bit counter and command byte, cleared at each frame start
  always_ff @(posedge i_sck or posedge link_idle) begin
    if (link_idle) begin
      bit_cnt <= 3'h0;
      cmd_done <= 1'b0;
      link_cmd <= 8'h00;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_end && !cmd_done) begin
        link_cmd <= next_shift;
        cmd_done <= 1'b1;
      end
    end
  end

  // Byte holding and event toggle survive frame end for the core
  always_ff @(posedge i_sck or negedge i_reset_n) begin
    if (!i_reset_n) begin
      shifter <= 8'h00;
      byte_hold <= 8'h00;
      byte_tgl <= 1'b0;
    end else begin
      shifter <= next_shift;
      if (byte_end) begin
        byte_hold <= next_shift;
        byte_tgl <= ~byte_tgl;
      end
    end
  end

  // Read data on the falling edge; snapshot frozen while frame is open
  always_ff @(negedge i_sck or posedge link_idle) begin
    if (link_idle) begin
      out_sh <= 8'h00;
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
    end else if (load_out) begin
      o_so <= snap_sel[7];
      out_sh <= {snap_sel[6:0], 1'b0};
      o_so_oe <= 1'b1;
    end else begin
      o_so <= out_sh[7];
      out_sh <= {out_sh[6:0], 1'b0};
    end
  end

  // Two-flop synchronisers; chip select has one more stage so the
  // last byte is always seen before the frame end
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wp_s <= 2'h3;
      cs_s <= 4'hF;
      tgl_s <= 3'h0;
    end else begin
      wp_s <= {wp_s[0], i_wp_n};
      cs_s <= {cs_s[2:0], i_cs_n};
      tgl_s <= {tgl_s[1:0], byte_tgl};
    end
  end

  wire byte_new = tgl_s[2] ^ tgl_s[1];
  wire frame_end = cs_s[2] & ~cs_s[3];
  wire frame_idle = cs_s[1];

  // Frame capture: command, three address bytes, data byte
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || frame_end) begin
      byte_idx <= 3'h0;
    end else if (byte_new) begin
      if (byte_idx != 3'h7) begin
        byte_idx <= byte_idx + 3'h1;
      end
      if (byte_idx == 3'h0) begin
        fcmd <= byte_hold;
      end
      if (byte_idx >= 3'h1 && byte_idx <= 3'h3) begin
        faddr <= {faddr[15:0], byte_hold};
      end
      if (byte_idx == 3'h1 || byte_idx == 3'h4) begin
        fdata <= byte_hold;
      end
    end
  end

  // Command decode
  wire is_write_enable_cmd = fcmd == CMD_WRITE_ENABLE;
  wire is_volatile_write_enable_cmd = fcmd == CMD_VOL_WRITE_ENABLE;
  wire is_write_disable_cmd = fcmd == CMD_WRITE_DISABLE;
  wire is_wrr = fcmd == CMD_REGISTER_WRITE;
  wire is_any_register_write_cmd = fcmd == CMD_ANY_REGISTER_WRITE;
  wire is_clear_status_cmd = fcmd == CMD_CLEAR_STATUS;
  wire is_susp = fcmd == CMD_SUSPEND;
  wire is_arm = fcmd == CMD_SOFT_RESET_ARM;
  wire is_rst = fcmd == CMD_SOFT_RESET;
  wire is_erase = fcmd == CMD_SECTOR_ERASE || fcmd == CMD_BLOCK_ERASE ||
                  fcmd == CMD_CHIP_ERASE_A || fcmd == CMD_CHIP_ERASE_B;
  wire is_array = is_erase || fcmd == CMD_PAGE_PROGRAM;
  wire busy_ok = fcmd == CMD_STATUS_ONE_READ ||
                 fcmd == CMD_STATUS_TWO_READ ||
                 fcmd == CMD_ANY_REGISTER_READ ||
                 is_susp || is_clear_status_cmd || is_arm || is_rst;

  // Pin doubles as data line 2 in quad modes, so protection drops
  wire wp_level = wp_s[1] | i_four_wire_mode | i_quad_mode;
  wire reg_locked = protect_lock & ~wp_level;
  wire accepted = frame_end & (byte_idx != 3'h0) &
                  (~busy_flag | busy_ok);
  wire wr_any_nv = is_any_register_write_cmd && byte_idx >= BYTES_ANY_WRITE &&
                   faddr == ADDR_STATUS_ONE_NV;
  wire wr_any_v = is_any_register_write_cmd && byte_idx >= BYTES_ANY_WRITE &&
                  faddr == ADDR_STATUS_ONE_V;
  wire wr_reg = is_wrr && byte_idx >= BYTES_REG_WRITE;
  // Lock gates only this register; others see o_register_lock
  wire wr_go = accepted & write_enable_latch & ~reg_locked &
               (wr_reg | wr_any_nv | wr_any_v);
  wire wr_nv = wr_go & (wr_any_nv | (wr_reg & ~vol_only));
  wire wr_vol = wr_go & ~wr_nv;
  wire arr_go = accepted & is_array & write_enable_latch;
  wire susp_go = accepted & is_susp & arr_run;
  wire clr_go = accepted & is_clear_status_cmd;
  wire rst_go = accepted & is_rst & rst_armed;
  wire op_ok = arr_run & i_op_done & ~i_op_fail;
  wire op_bad = arr_run & i_op_done & i_op_fail;
  wire nv_done = nv_busy & (nv_timer == 16'h0001);
  wire any_err = prog_err | erase_err;

  // Non-volatile copy; write latch and busy defaults are fixed constants
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      nv_lock <= PROTECT_LOCK_RST;
      nv_gran <= GRANULE_RST;
      nv_tb <= TOP_BOTTOM_RST;
      nv_bp <= BLOCK_PROTECT_RST;
    end else if (wr_nv) begin
      nv_lock <= fdata[BIT_PROTECT_LOCK];
      nv_gran <= fdata[BIT_GRANULE];
      nv_tb <= fdata[BIT_TOP_BOTTOM];
      nv_bp <= fdata[BP_MSB:BP_LSB];
    end
  end

  // Volatile protection fields, reloaded from defaults on any reset
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      protect_lock <= PROTECT_LOCK_RST;
      granule_select <= GRANULE_RST;
      top_bottom_select <= TOP_BOTTOM_RST;
      block_protect_field <= BLOCK_PROTECT_RST;
    end else if (rst_go) begin
      protect_lock <= nv_lock;
      granule_select <= nv_gran;
      top_bottom_select <= nv_tb;
      block_protect_field <= nv_bp;
    end else if (wr_go) begin
      // A non-volatile write drags the working copy along
      protect_lock <= fdata[BIT_PROTECT_LOCK];
      granule_select <= fdata[BIT_GRANULE];
      top_bottom_select <= fdata[BIT_TOP_BOTTOM];
      block_protect_field <= fdata[BP_MSB:BP_LSB];
    end
  end

  // Write latch: data bits 1:0 of a register write never reach it
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || rst_go) begin
      write_enable_latch <= WRITE_LATCH_DEFAULT;
    end else begin
      if ((accepted & is_write_disable_cmd) | clr_go) begin
        write_enable_latch <= 1'b0;
      end
      if (op_ok | nv_done | wr_vol) begin
        write_enable_latch <= 1'b0;
      end
      if (accepted & (is_write_enable_cmd | is_volatile_write_enable_cmd)) begin
        write_enable_latch <= 1'b1;
      end
    end
  end

  // Volatile-only target chosen by which enable came last
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || rst_go) begin
      vol_only <= 1'b0;
    end else if (accepted & (is_write_enable_cmd | is_volatile_write_enable_cmd)) begin
      vol_only <= is_volatile_write_enable_cmd;
    end
  end

  // Busy flag; an error holds it until clear-status
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || rst_go) begin
      busy_flag <= BUSY_FLAG_DEFAULT;
    end else begin
      if (op_ok | nv_done) begin
        busy_flag <= 1'b0;
      end
      if (clr_go & any_err & ~arr_run & ~nv_busy) begin
        busy_flag <= 1'b0;
      end
      if (arr_go | wr_nv | op_bad) begin
        busy_flag <= 1'b1;
      end
    end
  end

  // Error flags; a failure in the clearing cycle still sets them
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || rst_go) begin
      prog_err <= 1'b0;
      erase_err <= 1'b0;
    end else begin
      if (clr_go) begin
        prog_err <= 1'b0;
        erase_err <= 1'b0;
      end
      if (op_bad & arr_erase) begin
        erase_err <= 1'b1;
      end
      if (op_bad & ~arr_erase) begin
        prog_err <= 1'b1;
      end
    end
  end

  // Array operation tracking and non-volatile write timer
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || rst_go) begin
      arr_run <= 1'b0;
      arr_erase <= 1'b0;
      nv_busy <= 1'b0;
      nv_timer <= 16'h0000;
    end else begin
      if (arr_go) begin
        arr_run <= 1'b1;
        arr_erase <= is_erase;
      end else if (i_op_done) begin
        arr_run <= 1'b0;
      end
      if (wr_nv) begin
        nv_busy <= 1'b1;
        nv_timer <= 16'(NV_WRITE_CYCLES);
      end else if (nv_busy) begin
        nv_timer <= nv_timer - 16'h0001;
        nv_busy <= ~nv_done;
      end
    end
  end

  // Reset pair: the arm command must be the frame just before
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      rst_armed <= 1'b0;
    end else if (accepted) begin
      rst_armed <= is_arm;
    end
  end

  // Registered outputs; the range decode itself lives in the array engine
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_op_start <= 1'b0;
      o_op_erase <= 1'b0;
      o_suspend <= 1'b0;
      o_register_lock <= 1'b0;
    end else begin
      o_op_start <= arr_go;
      if (arr_go) begin
        o_op_erase <= is_erase;
      end
      o_suspend <= susp_go;
      o_register_lock <= reg_locked;
    end
  end

  assign o_granule_select = granule_select;
  assign o_top_bottom = top_bottom_select;
  assign o_block_protect = block_protect_field;
  assign o_write_enable = write_enable_latch;
  assign o_busy = busy_flag;

  // Read snapshots only move between frames, so the link sees stable words
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      snap_one <= 8'h00;
      snap_two <= 8'h00;
    end else if (frame_idle) begin
      snap_one <= {protect_lock, granule_select, top_bottom_select,
                   block_protect_field, write_enable_latch,
                   busy_flag};
      snap_two <= {1'b0, erase_err, prog_err, 5'h00};
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  lock_blocks_write_a: assert property (
    frame_end && reg_locked && (is_wrr || is_any_register_write_cmd) |=>
      $stable(nv_lock) && $stable(block_protect_field) && !nv_busy)
    else $error("locked register was written");
  unlocked_write_a: assert property (
    wr_vol |=> block_protect_field == $past(fdata[BP_MSB:BP_LSB]))
    else $error("volatile write lost");
  quad_unlocks_a: assert property (
    (i_quad_mode || i_four_wire_mode) |=> !o_register_lock)
    else $error("lock active in quad mode");
  lock_tracks_a: assert property (
    wr_nv |=> protect_lock == nv_lock)
    else $error("lock bit not tracking default");
  tb_tracks_a: assert property (
    wr_nv |=> top_bottom_select == nv_tb ##1 nv_busy)
    else $error("top-bottom not tracking default");
  write_enable_cmd_sets_a: assert property (
    accepted && is_write_enable_cmd |=> write_enable_latch && !$past(busy_flag))
    else $error("write enable not taken");
  done_clears_a: assert property (
    op_ok |=> !write_enable_latch && !busy_flag)
    else $error("latch left after success");
  nv_write_len_a: assert property (
    wr_nv |=> busy_flag [*8])
    else $error("busy dropped early");
  busy_refuse_a: assert property (
    busy_flag && frame_end && (is_write_enable_cmd || is_write_disable_cmd) && !op_ok && !nv_done
      |=> $stable(write_enable_latch))
    else $error("command taken while busy");
  suspend_run_a: assert property (
    o_suspend |-> $past(arr_run, 1))
    else $error("suspend without operation");
  err_holds_a: assert property (
    op_bad |=> busy_flag && any_err && write_enable_latch)
    else $error("error did not hold busy");
  clear_errs_a: assert property (
    clr_go && !op_bad |=> !prog_err && !erase_err)
    else $error("clear-status left errors");
  soft_reset_a: assert property (
    rst_go |=> write_enable_latch == WRITE_LATCH_DEFAULT &&
      busy_flag == BUSY_FLAG_DEFAULT)
    else $error("reset did not load defaults");
  reg_write_keep_a: assert property (
    wr_nv |=> busy_flag && $stable(write_enable_latch))
    else $error("register write touched latch");

  array_done_c: cover property (arr_go ##[1:200] op_ok);
  nv_write_c: cover property (wr_nv ##[1:100] nv_done);
  soft_reset_c: cover property (rst_go);
  error_clear_c: cover property (op_bad ##[1:200] clr_go);

endmodule

//--- dv/spi_host_model.sv
// SPI host model that sends command frames to the status register block
`timescale 1ns/1ns
module spi_host_model (
  // Serial link toward the device
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe
);
  // Link idles deselected with the clock parked low
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end

  // One frame of n bytes, MSB first; second byte is captured as read data
  task automatic xfer(input int n, input logic [39:0] tx,
                      output logic [7:0] rx);
    int i;
    rx = 8'h00;
    o_cs_n = 1'b0;
    for (i = 8 * n - 1; i >= 0; i--) begin
      o_si = tx[i];
      #24 o_sck = 1'b1;
      // Undriven output must not pass as data
      if (i < 8 * n - 8 && i >= 8 * n - 16) begin
        rx = {rx[6:0], (i_so_oe === 1'b1) ? i_so : 1'bx};
      end
      #24 o_sck = 1'b0;
    end
    // Released line shows the inverse, never the stale bit
    o_si = ~o_si;
    #24 o_cs_n = 1'b1;
    // Gap well over the minimum, lets the command land in the core
    #500;
  endtask
endmodule

//--- dv/status_one_protection_test.sv
// Self-checking bench for the status register one protection block
`timescale 1ns/1ns
module status_one_protection_test;
  import status_one_pkg::*;
  logic i_clk, i_reset_n, i_wp_n, i_four_wire_mode, i_quad_mode;
  logic i_op_done, i_op_fail, o_so, o_so_oe, o_op_start, o_op_erase;
  logic o_suspend, o_register_lock, o_granule_select, o_top_bottom;
  logic o_write_enable, o_busy, sck, cs_n, si;
  logic [2:0] o_block_protect;
  logic [7:0] rx;
  int failures = 0;
  int checks = 0;
  int starts = 0;
  int suspends = 0;

  status_one_protection #(.NV_WRITE_CYCLES(80)) status_one_protection_inst (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sck(sck), .i_cs_n(cs_n),
    .i_si(si), .o_so(o_so), .o_so_oe(o_so_oe), .i_wp_n(i_wp_n),
    .i_four_wire_mode(i_four_wire_mode), .i_quad_mode(i_quad_mode),
    .i_op_done(i_op_done), .i_op_fail(i_op_fail), .o_op_start(o_op_start),
    .o_op_erase(o_op_erase), .o_suspend(o_suspend),
    .o_register_lock(o_register_lock), .o_granule_select(o_granule_select),
    .o_top_bottom(o_top_bottom), .o_block_protect(o_block_protect),
    .o_write_enable(o_write_enable), .o_busy(o_busy));

  spi_host_model spi_host_model_inst (
    .o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(o_so), .i_so_oe(o_so_oe));

  // Core clock, 50 ns period
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Count one-cycle pulses toward the array engine
  always @(posedge i_clk) begin
    if (o_op_start === 1'b1) starts++;
    if (o_suspend === 1'b1) suspends++;
  end

  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Frames start a fixed delay after a core clock edge
  task automatic frame(input int n, input logic [39:0] tx);
    @(posedge i_clk);
    #2;
    spi_host_model_inst.xfer(n, tx, rx);
  endtask

  task automatic cmd(input logic [7:0] c);
    frame(1, {32'h0, c});
  endtask

  task automatic rd(input logic [7:0] c);
    frame(2, {24'h0, c, 8'h00});
  endtask

  task automatic wr01(input logic [7:0] d);
    frame(2, {24'h0, CMD_REGISTER_WRITE, d});
  endtask

  // Engine reports completion with a one-cycle pulse
  task automatic done(input logic fail);
    @(posedge i_clk);
    #2;
    i_op_done = 1'b1;
    i_op_fail = fail;
    @(posedge i_clk);
    #2;
    i_op_done = 1'b0;
    i_op_fail = 1'b0;
    repeat (3) @(posedge i_clk);
    #2;
  endtask

  // Host polls busy with a bounded wait before the next write
  task automatic wait_idle;
    for (int k = 0; k < 300 && o_busy !== 1'b0; k++) @(posedge i_clk);
    #2;
    chk("busy idle", 8'h00, 8'(o_busy));
  endtask

  // Watchdog cuts a hang short
  initial begin
    #500000;
    failures++;
    end_of_test();
  end

  initial begin
    i_reset_n = 1'b0;
    i_wp_n = 1'b1;
    i_four_wire_mode = 1'b0;
    i_quad_mode = 1'b0;
    i_op_done = 1'b0;
    i_op_fail = 1'b0;
    repeat (6) @(posedge i_clk);
    #2;
    i_reset_n = 1'b1;
    repeat (4) @(posedge i_clk);
    // Defaults after power-up
    chk("lock out", 8'h00, 8'(o_register_lock));
    chk("bp field", 8'h00, 8'(o_block_protect));
    rd(CMD_STATUS_ONE_READ);
    chk("status one reset", 8'h00, rx);
    // Latch set and clear
    cmd(CMD_WRITE_ENABLE);
    rd(CMD_STATUS_ONE_READ);
    chk("status latch set", 8'h02, rx);
    cmd(CMD_WRITE_DISABLE);
    chk("latch cleared", 8'h00, 8'(o_write_enable));
    // Volatile write; low two data bits must not land
    cmd(CMD_VOL_WRITE_ENABLE);
    wr01(8'hE7);
    chk("granule", 8'h01, 8'(o_granule_select));
    chk("top bottom", 8'h01, 8'(o_top_bottom));
    chk("bp field", 8'h01, 8'(o_block_protect));
    rd(CMD_STATUS_ONE_READ);
    chk("status vol write", 8'hE4, rx);
    // Locked with the pin low: register write ignored
    @(posedge i_clk) #2 i_wp_n = 1'b0;
    repeat (5) @(posedge i_clk);
    #2;
    chk("lock out", 8'h01, 8'(o_register_lock));
    cmd(CMD_VOL_WRITE_ENABLE);
    wr01(8'h00);
    rd(CMD_STATUS_ONE_READ);
    chk("status locked", 8'hE6, rx);
    // Either mode bit frees the pin and the protection
    for (int m = 0; m < 2; m++) begin
      @(posedge i_clk) #2 i_quad_mode = (m == 0);
      i_four_wire_mode = (m == 1);
      repeat (3) @(posedge i_clk);
      #2;
      chk("lock in mode", 8'h00, 8'(o_register_lock));
    end
    wr01(8'h00);
    rd(CMD_STATUS_ONE_READ);
    chk("status mode write", 8'h00, rx);
    // Lock clear: pin low still allows writes
    @(posedge i_clk) #2 i_four_wire_mode = 1'b0;
    cmd(CMD_VOL_WRITE_ENABLE);
    wr01(8'h1C);
    rd(CMD_STATUS_ONE_READ);
    chk("status unlocked", 8'h1C, rx);
    // Non-volatile write carries lock and top-bottom to the working copy
    cmd(CMD_WRITE_ENABLE);
    frame(5, {CMD_ANY_REGISTER_WRITE, ADDR_STATUS_ONE_NV, 8'hA0});
    chk("busy nv write", 8'h01, 8'(o_busy));
    chk("lock follows", 8'h01, 8'(o_register_lock));
    chk("tb follows", 8'h01, 8'(o_top_bottom));
    cmd(CMD_WRITE_DISABLE);
    rd(CMD_STATUS_ONE_READ);
    chk("status busy", 8'hA3, rx);
    wait_idle();
    chk("latch after nv", 8'h00, 8'(o_write_enable));
    // Program runs though registers are locked
    cmd(CMD_WRITE_ENABLE);
    cmd(CMD_PAGE_PROGRAM);
    chk("op starts", 8'h01, 8'(starts));
    chk("op erase", 8'h00, 8'(o_op_erase));
    cmd(CMD_SUSPEND);
    chk("suspend running", 8'h01, 8'(suspends));
    done(1'b0);
    chk("busy done", 8'h00, 8'(o_busy));
    chk("latch done", 8'h00, 8'(o_write_enable));
    cmd(CMD_SUSPEND);
    chk("suspend idle", 8'h01, 8'(suspends));
    // Failed erase holds busy until clear-status
    @(posedge i_clk) #2 i_wp_n = 1'b1;
    cmd(CMD_WRITE_ENABLE);
    cmd(CMD_SECTOR_ERASE);
    chk("op erase", 8'h01, 8'(o_op_erase));
    done(1'b1);
    chk("busy error", 8'h01, 8'(o_busy));
    chk("latch error", 8'h01, 8'(o_write_enable));
    cmd(CMD_PAGE_PROGRAM);
    chk("op refused", 8'h02, 8'(starts));
    rd(CMD_STATUS_TWO_READ);
    chk("status two err", 8'h40, rx);
    cmd(CMD_CLEAR_STATUS);
    chk("busy cleared", 8'h00, 8'(o_busy));
    chk("latch cleared", 8'h00, 8'(o_write_enable));
    rd(CMD_STATUS_TWO_READ);
    chk("status two clr", 8'h00, rx);
    // Software reset reloads the working copy and the latch default
    cmd(CMD_VOL_WRITE_ENABLE);
    wr01(8'h1C);
    cmd(CMD_WRITE_ENABLE);
    cmd(CMD_SOFT_RESET_ARM);
    cmd(CMD_SOFT_RESET);
    rd(CMD_STATUS_ONE_READ);
    chk("status soft rst", 8'hA0, rx);
    chk("latch soft rst", 8'h00, 8'(o_write_enable));
    // Any-register write to the working copy leaves busy clear
    cmd(CMD_WRITE_ENABLE);
    frame(5, {CMD_ANY_REGISTER_WRITE, ADDR_STATUS_ONE_V, 8'h1C});
    chk("bp any write", 8'h07, 8'(o_block_protect));
    chk("busy any write", 8'h00, 8'(o_busy));
    chk("latch any write", 8'h00, 8'(o_write_enable));
    end_of_test();
  end
endmodule
